// ### core/gvf_dev.sv
// Display engine: command decoder, display memory and refresh scan.
`include "gvf_params.svh"
`default_nettype none
module gvf_dev
  import gvf_pkg::*;
#(
  parameter int CLEAR_CYC = `GVF_CLEAR_CYC
) (
  // Clock and reset
  input  wire logic   core_clk,
  input  wire logic   resetn,
  // Link to controller
  gvf_if.dev          link,
  // Display scan output
  output var  logic [7:0] disp_byte_o,
  output var  logic [6:0] disp_col_o,
  output var  logic [3:0] disp_row_o,
  output var  logic       disp_gray_o,
  // Module state
  output var  logic       power_on_o,
  output var  logic [7:0] lum_o
);

  // --------------------------------------------------------------------
  // Memory address arithmetic
  // --------------------------------------------------------------------
  function automatic logic [10:0] scan_addr(input logic [11:0] start,
                                            input logic [6:0]  col,
                                            input logic [3:0]  row,
                                            input logic        gray);
    logic [10:0] step;
    step = gray ? {col, row} : {1'b0, col, row[2:0]};
    return start[10:0] + step;
  endfunction

  logic [7:0]  mem [0:2047];
  gvf_state_t  state_reg;
  logic [14:0] clr_cnt_reg;
  logic [7:0]  pend_reg;
  logic [1:0]  scr_reg;
  gvf_comb_t   comb_reg;
  logic        inc_reg;
  logic        gray_reg;
  logic [7:0]  fmode_reg;
  logic [11:0] start1_reg;
  logic [11:0] start2_reg;
  logic [11:0] rw_reg;
  logic [7:0]  rlatch_reg;
  logic [6:0]  col_reg;
  logic [3:0]  row_reg;
  logic [7:0]  rdata_reg;
  logic        rd_valid_reg;
  logic        frame_reg;
  logic        busy_reg;
  logic [7:0]  disp_byte_reg;
  logic [6:0]  disp_col_reg;
  logic [3:0]  disp_row_reg;
  logic        pwr_reg;
  logic [7:0]  lum_reg;

  // --------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------
  wire         idle     = (state_reg == GVF_ST_IDLE);
  // Bytes that arrive while clearing are dropped whole.
  wire         cmd_in   = link.wr_stb & link.cd & idle;
  wire         dat_in   = link.wr_stb & ~link.cd & idle;
  wire         pix_wr   = dat_in & (pend_reg == `GVF_CMD_PIXWR);
  wire         pix_rd   = link.rd_stb & idle;
  wire         rw_step  = (pix_wr | pix_rd) & inc_reg;
  wire [11:0]  rw_inc   = {1'b0, rw_reg[10:0] + 11'd1};
  wire         clr_go   = cmd_in & (link.wdata == `GVF_CMD_CLEAR);
  wire         clr_wr   = (state_reg == GVF_ST_CLEAR) &
                          (clr_cnt_reg[14:11] == 4'h0);
  wire         clr_done = (clr_cnt_reg == 15'(CLEAR_CYC - 1));
  wire [3:0]   row_last = gray_reg ? `GVF_ROW_LAST_G : `GVF_ROW_LAST_M;
  wire         row_end  = (row_reg == row_last);
  wire         frm_end  = row_end & (col_reg == `GVF_COL_LAST);
  wire [7:0]   b1       = mem[scan_addr(start1_reg, col_reg, row_reg,
                                        gray_reg)];
  wire [7:0]   b2       = mem[scan_addr(start2_reg, col_reg, row_reg,
                                        gray_reg)];
  logic [7:0]  mix;

  // In gray mode the screen 1 pixel pairs pass through unchanged to the drivers while any screen is on and luminance is not blank.
  always_comb begin
    mix = 8'h00;
    if (gray_reg) begin
      mix = (scr_reg != 2'b00) ? b1 : 8'h00;
    end else begin
      case (comb_reg)
        GVF_CMB_OR:   mix = b1 | b2;
        GVF_CMB_XOR:  mix = b1 ^ b2;
        GVF_CMB_AND:  mix = b1 & b2;
        default: begin
          mix = scr_reg[0] ? b1 : (scr_reg[1] ? b2 : 8'h00);
        end
      endcase
    end
    if (lum_reg == `GVF_LUM_BLANK) begin
      mix = 8'h00;
    end
  end

  // --------------------------------------------------------------------
  // Memory
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (clr_wr) begin
      mem[clr_cnt_reg[10:0]] <= 8'h00;
    end else if (pix_wr) begin
      mem[rw_reg[10:0]] <= link.wdata;
    end
  end

  // --------------------------------------------------------------------
  // Clear sequencer
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg   <= GVF_ST_IDLE;
      clr_cnt_reg <= 15'h0000;
      busy_reg    <= 1'b0;
    end else begin
      case (state_reg)
        GVF_ST_IDLE: begin
          clr_cnt_reg <= 15'h0000;
          if (clr_go) begin
            state_reg <= GVF_ST_CLEAR;
            busy_reg  <= 1'b1;
          end
        end
        GVF_ST_CLEAR: begin
          clr_cnt_reg <= clr_cnt_reg + 15'h0001;
          if (clr_done) begin
            state_reg <= GVF_ST_IDLE;
            busy_reg  <= 1'b0;
          end
        end
        default: begin
          state_reg <= GVF_ST_IDLE;
          busy_reg  <= 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Command decoder
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pend_reg  <= 8'hff;
      scr_reg   <= 2'b00;
      comb_reg  <= GVF_CMB_NONE;
      inc_reg   <= 1'b1;
      gray_reg  <= 1'b0;
      fmode_reg <= `GVF_FP_NONE;
      pwr_reg   <= 1'b1;
      lum_reg   <= `GVF_LUM_FULL;
    end else if (cmd_in) begin
      pend_reg <= link.wdata;
      case (link.wdata)
        `GVF_CMD_OFF: begin
          scr_reg  <= 2'b00;
          comb_reg <= GVF_CMB_NONE;
        end
        `GVF_CMD_SCR1: begin
          scr_reg  <= 2'b01;
          comb_reg <= GVF_CMB_NONE;
        end
        `GVF_CMD_SCR2: begin
          scr_reg  <= 2'b10;
          comb_reg <= GVF_CMB_NONE;
        end
        `GVF_CMD_OR, `GVF_CMD_XOR, `GVF_CMD_AND: begin
          scr_reg  <= 2'b11;
          comb_reg <= gvf_comb_t'(link.wdata[1:0] + 2'd1);
        end
        `GVF_CMD_INC:  inc_reg <= 1'b1;
        `GVF_CMD_HOLD: inc_reg <= 1'b0;
        default: begin
        end
      endcase
    end else if (dat_in) begin
      case (pend_reg)
        `GVF_CMD_POWER: pwr_reg <= (link.wdata == `GVF_PWR_ON);
        // Luminance codes are applied as written; neither the engine nor the controller clamps them to range.
        `GVF_CMD_LUM:   lum_reg <= link.wdata;
        `GVF_CMD_MODE: begin
          if (link.wdata == `GVF_MODE_MONO) begin
            gray_reg <= 1'b0;
          end else if (link.wdata == `GVF_MODE_GRAY) begin
            gray_reg <= 1'b1;
          end
        end
        `GVF_CMD_FRAME: begin
          if (link.wdata == `GVF_FP_NONE || link.wdata == `GVF_FP_POS ||
              link.wdata == `GVF_FP_NEG) begin
            fmode_reg <= link.wdata;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Address registers
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      start1_reg <= 12'h000;
      start2_reg <= 12'h000;
      rw_reg     <= 12'h000;
    end else if (dat_in && pend_reg == `GVF_CMD_S1LO) begin
      start1_reg[7:0] <= link.wdata;
    end else if (dat_in && pend_reg == `GVF_CMD_S1HI) begin
      start1_reg[11:8] <= link.wdata[3:0];
    end else if (dat_in && pend_reg == `GVF_CMD_S2LO) begin
      start2_reg[7:0] <= link.wdata;
    end else if (dat_in && pend_reg == `GVF_CMD_S2HI) begin
      start2_reg[11:8] <= link.wdata[3:0];
    end else if (dat_in && pend_reg == `GVF_CMD_RWLO) begin
      rw_reg[7:0] <= link.wdata;
    end else if (dat_in && pend_reg == `GVF_CMD_RWHI) begin
      rw_reg[11:8] <= link.wdata[3:0];
    end else if (rw_step) begin
      rw_reg <= rw_inc;
    end
  end

  // --------------------------------------------------------------------
  // Read path: each read returns the byte fetched by the read before it,
  // so the first read after a fresh address is stale by construction.
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rlatch_reg   <= 8'h00;
      rdata_reg    <= 8'h00;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= pix_rd;
      if (pix_rd) begin
        rdata_reg  <= rlatch_reg;
        rlatch_reg <= mem[rw_reg[10:0]];
      end
    end
  end

  // --------------------------------------------------------------------
  // Refresh scan and frame pulse
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      col_reg       <= 7'h00;
      row_reg       <= 4'h0;
      disp_byte_reg <= 8'h00;
      disp_col_reg  <= 7'h00;
      disp_row_reg  <= 4'h0;
      frame_reg     <= 1'b0;
    end else begin
      row_reg       <= row_end ? 4'h0 : row_reg + 4'h1;
      col_reg       <= row_end ? col_reg + 7'h01 : col_reg;
      disp_byte_reg <= mix;
      disp_col_reg  <= col_reg;
      disp_row_reg  <= row_reg;
      case (fmode_reg)
        `GVF_FP_POS: frame_reg <= frm_end;
        `GVF_FP_NEG: frame_reg <= ~frm_end;
        default:     frame_reg <= 1'b0;
      endcase
    end
  end

  assign link.rdata    = rdata_reg;
  assign link.rd_valid = rd_valid_reg;
  assign link.busy     = busy_reg;
  assign link.frame    = frame_reg;
  assign disp_byte_o   = disp_byte_reg;
  assign disp_col_o    = disp_col_reg;
  assign disp_row_o    = disp_row_reg;
  assign disp_gray_o   = gray_reg;
  assign power_on_o    = pwr_reg;
  assign lum_o         = lum_reg;

endmodule : gvf_dev
`default_nettype wire

// ### core/gvf_params.svh
// Constants shared by both ends of the graphic display command link.
`ifndef GVF_PARAMS_SVH
`define GVF_PARAMS_SVH

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define GVF_CMD_OFF      8'h00
`define GVF_CMD_SCR1     8'h01
`define GVF_CMD_SCR2     8'h02
`define GVF_CMD_INC      8'h04
`define GVF_CMD_HOLD     8'h05
`define GVF_CMD_CLEAR    8'h06
`define GVF_CMD_POWER    8'h07
`define GVF_CMD_PIXWR    8'h08
`define GVF_CMD_PIXRD    8'h09
`define GVF_CMD_S1LO     8'h0a
`define GVF_CMD_S1HI     8'h0b
`define GVF_CMD_S2LO     8'h0c
`define GVF_CMD_S2HI     8'h0d
`define GVF_CMD_RWLO     8'h0e
`define GVF_CMD_RWHI     8'h0f
`define GVF_CMD_OR       8'h10
`define GVF_CMD_XOR      8'h11
`define GVF_CMD_AND      8'h12
`define GVF_CMD_LUM      8'h13
`define GVF_CMD_MODE     8'h14
`define GVF_CMD_FRAME    8'h15

// ----------------------------------------------------------------------
// Setting values
// ----------------------------------------------------------------------
`define GVF_PWR_ON       8'h00
`define GVF_MODE_MONO    8'h10
`define GVF_MODE_GRAY    8'h14
`define GVF_LUM_FULL     8'h00
`define GVF_LUM_BLANK    8'hff
`define GVF_LUM_MONO_MAX 8'h2a
`define GVF_LUM_GRAY_MAX 8'h32
`define GVF_FP_NONE      8'h00
`define GVF_FP_POS       8'h01
`define GVF_FP_NEG       8'h03

// ----------------------------------------------------------------------
// Memory map and scan geometry
// ----------------------------------------------------------------------
`define GVF_MEM_TOP      11'h7ff
`define GVF_COL_LAST     7'h7f
`define GVF_ROW_LAST_M   4'h7
`define GVF_ROW_LAST_G   4'hf

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define GVF_CLK_PERIOD_NS 10
`define GVF_CLEAR_NS      260000
`define GVF_CLEAR_CYC     ((`GVF_CLEAR_NS + `GVF_CLK_PERIOD_NS - 1) / `GVF_CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// Host register offsets and fields
// ----------------------------------------------------------------------
`define GVF_REG_TX       12'h000
`define GVF_REG_RX       12'h004
`define GVF_REG_STAT     12'h008
`define GVF_TX_CD_BIT    8
`define GVF_TX_RD_BIT    9
`define GVF_RX_VAL_BIT   8

`endif

// ### core/gvf_pkg.sv
// Types shared by both ends of the graphic display command link.
`default_nettype none
package gvf_pkg;
  typedef enum logic [1:0] {
    GVF_ST_IDLE  = 2'b01,
    GVF_ST_CLEAR = 2'b10
  } gvf_state_t;

  typedef enum logic [1:0] {
    GVF_CMB_NONE = 2'd0,
    GVF_CMB_OR   = 2'd1,
    GVF_CMB_XOR  = 2'd2,
    GVF_CMB_AND  = 2'd3
  } gvf_comb_t;
endpackage : gvf_pkg
`default_nettype wire

// ### core/gvf_if.sv
// Byte link between the display controller and the display engine.
`default_nettype none
interface gvf_if;
  logic       wr_stb;
  logic       cd;
  logic [7:0] wdata;
  logic       rd_stb;
  logic [7:0] rdata;
  logic       rd_valid;
  logic       busy;
  logic       frame;

  modport dev  (input wr_stb, cd, wdata, rd_stb,
                output rdata, rd_valid, busy, frame);
  modport host (output wr_stb, cd, wdata, rd_stb,
                input rdata, rd_valid, busy, frame);
endinterface : gvf_if
`default_nettype wire

// ### core/gvf_host.sv
// Display controller: APB registers driving the display command link.
`include "gvf_params.svh"
`default_nettype none
module gvf_host
  import gvf_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Link to display
  gvf_if.host              link
);

  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        perr_reg;
  logic        pend_reg;
  logic        pend_rd_reg;
  logic        pend_cd_reg;
  logic [7:0]  pend_byte_reg;
  logic        wr_stb_reg;
  logic        rd_stb_reg;
  logic        cd_reg;
  logic [7:0]  wdata_reg;
  logic [7:0]  rx_reg;
  logic        rx_val_reg;
  logic        dummy_reg;
  logic        mode_set_reg;
  logic        drop_reg;
  logic        frame_d_reg;
  logic [15:0] frames_reg;

  // --------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------
  wire setup   = psel & ~penable & ~pready_reg;
  wire access  = psel & penable & pready_reg;
  wire hit_tx  = (paddr == `GVF_REG_TX);
  wire hit_rx  = (paddr == `GVF_REG_RX);
  wire hit_st  = (paddr == `GVF_REG_STAT);
  wire mapped  = hit_tx | hit_rx | hit_st;
  wire tx_wr   = access & pwrite & hit_tx & ~pend_reg;
  wire rx_rd   = access & ~pwrite & hit_rx;
  wire [7:0] tb = pwdata[7:0];
  wire tx_cd   = pwdata[`GVF_TX_CD_BIT];
  // Commands other than the mode command are refused until it is sent.
  wire ok_mode = mode_set_reg | ~tx_cd | (tb == `GVF_CMD_MODE);
  wire tx_ok   = tx_wr & ok_mode;
  wire launch  = pend_reg & ~link.busy & ~wr_stb_reg & ~rd_stb_reg;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      perr_reg   <= 1'b0;
    end else begin
      pready_reg <= setup;
      perr_reg   <= setup & ~mapped;
      if (setup) begin
        prdata_reg <= hit_rx ? {23'h0, rx_val_reg, rx_reg} :
                      hit_st ? {frames_reg, 11'h000, drop_reg, mode_set_reg,
                                link.frame, pend_reg, link.busy} : 32'h0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Link sender
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pend_reg      <= 1'b0;
      pend_rd_reg   <= 1'b0;
      pend_cd_reg   <= 1'b0;
      pend_byte_reg <= 8'h00;
      wr_stb_reg    <= 1'b0;
      rd_stb_reg    <= 1'b0;
      cd_reg        <= 1'b0;
      wdata_reg     <= 8'h00;
      mode_set_reg  <= 1'b0;
      drop_reg      <= 1'b0;
    end else begin
      wr_stb_reg <= launch & ~pend_rd_reg;
      rd_stb_reg <= launch & pend_rd_reg;
      if (launch) begin
        pend_reg  <= 1'b0;
        cd_reg    <= pend_cd_reg;
        wdata_reg <= pend_byte_reg;
      end else if (tx_ok) begin
        pend_reg      <= 1'b1;
        pend_rd_reg   <= pwdata[`GVF_TX_RD_BIT];
        pend_cd_reg   <= tx_cd;
        pend_byte_reg <= tb;
      end
      if (tx_wr & ~ok_mode) begin
        drop_reg <= 1'b1;
      end
      if (tx_ok & tx_cd & (tb == `GVF_CMD_MODE)) begin
        mode_set_reg <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Read capture and frame counting
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rx_reg      <= 8'h00;
      rx_val_reg  <= 1'b0;
      dummy_reg   <= 1'b0;
      frame_d_reg <= 1'b0;
      frames_reg  <= 16'h0000;
    end else begin
      frame_d_reg <= link.frame;
      if (link.frame & ~frame_d_reg) begin
        frames_reg <= frames_reg + 16'h0001;
      end
      if (wr_stb_reg & cd_reg & (wdata_reg == `GVF_CMD_PIXRD)) begin
        dummy_reg <= 1'b1;
      end else if (link.rd_valid) begin
        dummy_reg <= 1'b0;
      end
      if (link.rd_valid & ~dummy_reg) begin
        rx_reg     <= link.rdata;
        rx_val_reg <= 1'b1;
      end else if (rx_rd) begin
        rx_val_reg <= 1'b0;
      end
    end
  end

  assign prdata     = prdata_reg;
  assign pready     = pready_reg;
  assign pslverr    = perr_reg;
  assign link.wr_stb = wr_stb_reg;
  assign link.rd_stb = rd_stb_reg;
  assign link.cd     = cd_reg;
  assign link.wdata  = wdata_reg;

endmodule : gvf_host
`default_nettype wire

// ### test/gvf_checker.sv
// Concurrent checks on the byte link between controller and engine.
`default_nettype none
module gvf_checker #(
  parameter int CLEAR_CYC = 2100
) (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       resetn,
  // Link signals
  input wire logic       wr_stb,
  input wire logic       cd,
  input wire logic [7:0] wdata,
  input wire logic       rd_stb,
  input wire logic [7:0] rdata,
  input wire logic       rd_valid,
  input wire logic       busy,
  input wire logic       frame
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------------
  // Shadow of the engine's settings
  // --------------------------------------------------------------------
  logic [7:0] cmd_reg;
  logic [7:0] fpm_reg;
  logic       gray_reg;
  logic       seen_reg;
  int         bcnt_reg;
  int         gap_reg;
  wire        set_w = wr_stb && !cd && !busy;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cmd_reg  <= 8'hff;
      fpm_reg  <= 8'h00;
      gray_reg <= 1'b0;
      seen_reg <= 1'b0;
      bcnt_reg <= 0;
      gap_reg  <= 0;
    end else begin
      if (wr_stb && cd && !busy) cmd_reg <= wdata;
      if (set_w && cmd_reg == 8'h15 && wdata inside {8'h00, 8'h01, 8'h03})
        fpm_reg <= wdata;
      if (set_w && cmd_reg == 8'h14 && wdata inside {8'h10, 8'h14})
        gray_reg <= wdata[2];
      // Any link write may move the scan, so the next gap is not judged.
      seen_reg <= wr_stb ? 1'b0 : (frame ? 1'b1 : seen_reg);
      bcnt_reg <= busy ? bcnt_reg + 1 : 0;
      gap_reg  <= frame ? 0 : gap_reg + 1;
    end
  end
  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  chk_read_answer: assert property (rd_stb && !busy |=> rd_valid)
    else $error("read request not answered next cycle");
  chk_read_cause: assert property (rd_valid |-> $past(rd_stb))
    else $error("read data valid without a request");
  chk_rdata_hold: assert property ($changed(rdata) |-> rd_valid)
    else $error("read data moved without a read");
  chk_clear_busy: assert property (
    wr_stb && cd && wdata == 8'h06 && !busy |=> busy)
    else $error("clear did not raise busy");
  chk_busy_len: assert property ($fell(busy) |->
    bcnt_reg >= CLEAR_CYC - 2 && bcnt_reg <= CLEAR_CYC + 2)
    else $error("busy window has the wrong length");
  chk_stb_pulse: assert property (wr_stb |=> !wr_stb)
    else $error("byte strobe longer than one cycle");
  chk_fp_pos: assert property (
    fpm_reg == 8'h01 && $rose(frame) |=> !frame)
    else $error("positive frame pulse too long");
  chk_fp_neg: assert property (
    fpm_reg == 8'h03 && $fell(frame) |=> frame)
    else $error("negative frame pulse too long");
  chk_fp_none: assert property (
    fpm_reg == 8'h00 && $past(fpm_reg, 2) == 8'h00 |-> !frame)
    else $error("frame line active while disabled");
  chk_frame_gap: assert property (fpm_reg == 8'h01 && seen_reg &&
    $rose(frame) |-> gap_reg == (gray_reg ? 2047 : 1023))
    else $error("frame pulse spacing wrong");
endmodule : gvf_checker
`default_nettype wire

// ### test/graphic_vfd_command_engine_tb.sv
// Self-checking bench joining the display controller and engine.
`include "gvf_params.svh"
`default_nettype none
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin \
  err_total++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module graphic_vfd_command_engine_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CLR = 2100;
  localparam logic [7:0] SC [6] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h11, 8'h12};
  localparam logic [7:0] SE [6] = '{8'h00, 8'h81, 8'h0f, 8'h8f, 8'h8e, 8'h01};
  localparam logic [7:0] PAT [3] = '{8'haa, 8'h55, 8'h33};
  logic        core_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic        pready, pslverr, perr, power_on_o, disp_gray_o;
  logic [7:0]  disp_byte_o, lum_o, v;
  logic [6:0]  disp_col_o;
  logic [3:0]  disp_row_o;
  int          err_total = 0, compares = 0, cyc = 0, n, f0;
  gvf_if gvf_if_i ();
  gvf_dev #(.CLEAR_CYC(CLR)) gvf_dev_i (.core_clk(core_clk),
    .resetn(resetn), .link(gvf_if_i), .disp_byte_o(disp_byte_o),
    .disp_col_o(disp_col_o), .disp_row_o(disp_row_o),
    .disp_gray_o(disp_gray_o), .power_on_o(power_on_o), .lum_o(lum_o));
  gvf_host gvf_host_i (.core_clk(core_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(gvf_if_i));
  gvf_checker #(.CLEAR_CYC(CLR)) gvf_checker_i (.core_clk(core_clk),
    .resetn(resetn), .wr_stb(gvf_if_i.wr_stb), .cd(gvf_if_i.cd),
    .wdata(gvf_if_i.wdata), .rd_stb(gvf_if_i.rd_stb),
    .rdata(gvf_if_i.rdata), .rd_valid(gvf_if_i.rd_valid),
    .busy(gvf_if_i.busy), .frame(gvf_if_i.frame));
  always #5 core_clk = ~core_clk;
  // --------------------------------------------------------------------
  // Bus tasks
  // --------------------------------------------------------------------
  task automatic conclude();
    $display("compares=%0d mismatches=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 80000) begin
      err_total++;
      conclude();
    end
  end
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    do @(posedge core_clk); while (pready !== 1'b1);
    r = prdata;
    perr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // The controller holds one byte at a time, so wait until it has gone.
  task automatic tx(input logic c, input logic [7:0] b);
    apb(1, `GVF_REG_TX, {23'h0, c, b});
    do apb(0, `GVF_REG_STAT, 0); while (r[1] !== 1'b0);
  endtask
  task automatic cmd(input logic [7:0] c, input logic [7:0] s);
    tx(1, c);
    tx(0, s);
  endtask
  task automatic seta(input logic [11:0] a);
    cmd(8'h0e, a[7:0]);
    cmd(8'h0f, {4'h0, a[11:8]});
  endtask
  task automatic rdpx();
    apb(1, `GVF_REG_TX, 32'h200);
    do apb(0, `GVF_REG_RX, 0); while (r[8] !== 1'b1);
    v = r[7:0];
  endtask
  // The controller swallows the first read after 09H, so nothing arrives.
  task automatic rdskip();
    apb(1, `GVF_REG_TX, 32'h200);
    do apb(0, `GVF_REG_STAT, 0); while (r[1] !== 1'b0);
    apb(0, `GVF_REG_RX, 0);
    `CHK("dummy dropped", 1'b0, r[8])
  endtask
  // Two passes over the top-left dot so any setting change has landed.
  task automatic at00();
    repeat (2) begin
      @(posedge core_clk);
      do @(posedge core_clk);
      while (disp_col_o !== 7'h00 || disp_row_o !== 4'h0);
    end
    v = disp_byte_o;
  endtask
  task automatic fper(input logic p);
    do @(posedge core_clk); while (gvf_if_i.frame !== p);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (gvf_if_i.frame !== p);
  endtask
  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_mode();
    `CHK("lum", 8'h00, lum_o)
    `CHK("power", 1'b1, power_on_o)
    tx(1, 8'h01);
    apb(0, `GVF_REG_STAT, 0);
    `CHK("dropped", 2'b10, r[4:3])
    cmd(8'h14, 8'h10);
    apb(0, `GVF_REG_STAT, 0);
    `CHK("mode sent", 1'b1, r[3])
    apb(0, 12'h00c, 0);
    `CHK("slverr", 1'b1, perr)
    cmd(8'h07, 8'h00);
    `CHK("power", 1'b1, power_on_o)
    at00();
    `CHK("off", 8'h00, v)
    $display("test mode done");
  endtask
  task automatic t_clear();
    tx(1, 8'h06);
    n = cyc;
    apb(0, `GVF_REG_STAT, 0);
    `CHK("busy", 1'b1, r[0])
    do apb(0, `GVF_REG_STAT, 0); while (r[0] === 1'b1);
    n = cyc - n;
    `CHK("clear len", 1'b1, (n >= CLR && n <= CLR + 20))
    seta(12'h000);
    tx(1, 8'h09);
    rdskip();
    rdpx();
    `CHK("zeroed", 8'h00, v)
    $display("test clear done");
  endtask
  task automatic t_pixel();
    tx(1, 8'h04);
    seta(12'h7fe);
    tx(1, 8'h08);
    for (int i = 0; i < 3; i++) tx(0, PAT[i]);
    seta(12'h7fe);
    tx(1, 8'h09);
    rdskip();
    for (int i = 0; i < 3; i++) begin
      rdpx();
      `CHK("pixel", PAT[i], v)
    end
    tx(1, 8'h05);
    seta(12'h010);
    cmd(8'h0f, 8'h01);
    tx(1, 8'h08);
    tx(0, 8'h11);
    tx(0, 8'h22);
    tx(1, 8'h04);
    seta(12'h110);
    tx(1, 8'h09);
    rdskip();
    rdpx();
    `CHK("held", 8'h22, v)
    rdpx();
    `CHK("next", 8'h00, v)
    $display("test pixel done");
  endtask
  task automatic t_disp();
    seta(12'h000);
    cmd(8'h08, 8'h81);
    seta(12'h008);
    cmd(8'h08, 8'h0f);
    cmd(8'h0a, 8'h00);
    cmd(8'h0b, 8'h00);
    cmd(8'h0c, 8'h08);
    cmd(8'h0d, 8'h00);
    for (int i = 0; i < 6; i++) begin
      tx(1, SC[i]);
      at00();
      `CHK("screen", SE[i], v)
    end
    cmd(8'h13, 8'hff);
    at00();
    `CHK("blank", 8'h00, v)
    for (int i = 0; i < 8; i++) begin
      cmd(8'h13, 8'(i * 6));
      `CHK("lum", 8'(i * 6), lum_o)
    end
    $display("test display done");
  endtask
  task automatic t_frame();
    cmd(8'h15, 8'h01);
    fper(1);
    `CHK("pos period", 1024, n)
    apb(0, `GVF_REG_STAT, 0);
    f0 = r[31:16];
    fper(1);
    apb(0, `GVF_REG_STAT, 0);
    `CHK("frames", f0 + 2, int'(r[31:16]))
    cmd(8'h15, 8'h03);
    fper(0);
    `CHK("neg period", 1024, n)
    cmd(8'h15, 8'h00);
    repeat (4) @(posedge core_clk);
    n = 0;
    repeat (1100) begin
      @(posedge core_clk);
      if (gvf_if_i.frame !== 1'b0) n++;
    end
    `CHK("no pulse", 0, n)
    cmd(8'h14, 8'h14);
    cmd(8'h15, 8'h01);
    fper(1);
    `CHK("gray period", 2048, n)
    `CHK("gray", 1'b1, disp_gray_o)
    $display("test frame done");
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    resetn <= 1;
    t_mode();
    t_clear();
    t_pixel();
    t_disp();
    t_frame();
    conclude();
  end
endmodule : graphic_vfd_command_engine_tb
`default_nettype wire
